// file: logic/tcp_ahb_slave.sv
`timescale 1ns/100ps
`default_nettype none
module tcp_ahb_slave import tcp_pkg::*; (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // register side
  tcp_reg_if.bus rif
);
  typedef struct packed {
    logic wr_pend;
    logic rd_pend;
    logic [7:0] addr;
    logic [31:0] rdata;
  } tcp_bus_state_t;

  tcp_bus_state_t s_reg, s_next;
  logic take;

  // reads take one wait state so a write in the cycle before is already visible
  assign take = hsel && (htrans == HTRANS_NONSEQ) && hready && ce && (hsize == HSIZE_WORD);
  assign hreadyout = ce && !s_reg.rd_pend;
  assign hresp = 1'b0;
  assign hrdata = s_reg.rdata;
  assign rif.wr_en = s_reg.wr_pend && ce;
  assign rif.addr = s_reg.addr;
  assign rif.wr_data = hwdata;

  always_comb begin
    s_next = s_reg;
    s_next.wr_pend = 1'b0;
    if (s_reg.rd_pend) begin
      s_next.rd_pend = 1'b0;
      s_next.rdata = rif.rd_data;
    end
    if (take) begin
      s_next.addr = haddr[7:0];
      s_next.wr_pend = hwrite;
      s_next.rd_pend = !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end
endmodule // tcp_ahb_slave
`default_nettype wire

// file: logic/tcp_pin_unit.sv
`timescale 1ns/100ps
`default_nettype none
module tcp_pin_unit (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // control
  input wire logic hold,
  input wire logic set_evt,
  input wire logic clr_evt,
  input wire logic act_hi,
  // pin level
  output logic pin_o
);
  typedef struct packed {
    logic active;
    logic level;
  } tcp_pin_state_t;

  tcp_pin_state_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (hold || clr_evt) begin
      s_next.active = 1'b0;
    end else if (set_evt) begin
      s_next.active = 1'b1;
    end
    // inactive level is the opposite of the chosen active level
    s_next.level = act_hi ? s_next.active : !s_next.active;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign pin_o = s_reg.level;
endmodule // tcp_pin_unit
`default_nettype wire

// file: logic/tcp_pkg.sv
`default_nettype none
package tcp_pkg;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CLK_EN = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_MODE = 8'h08;
  localparam logic [7:0] OFS_OUT_DIS = 8'h0C;
  localparam logic [7:0] OFS_LEVEL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IEN = 8'h1C;
  localparam logic [7:0] OFS_COUNT = 8'h20;
  localparam logic [7:0] OFS_CMP_BASE = 8'h24;
  localparam logic [7:0] OFS_BUF_BASE = 8'h34;
  localparam logic [7:0] SLOT_SPAN = 8'h10;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CLK_GATE_BIT = 4;
  localparam int RUN_BIT = 0;
  localparam int CONT_BIT = 2;
  localparam int BUF_LSB = 4;
  localparam int FLAG_BIT = 0;
  // compare slots: 0 period, 1 pin a set, 2 pin b reset, 3 pin b set
  localparam int SLOT_PERIOD = 0;
  localparam int SLOT_A_SET = 1;
  localparam int SLOT_B_RST = 2;
  localparam int SLOT_B_SET = 3;
  // ----------------------------------------------------------------
  // values after reset, and AHB transfer codes
  // ----------------------------------------------------------------
  localparam logic [1:0] OUT_DIS_RST = 2'h3;
  localparam logic [1:0] LEVEL_RST = 2'h3;
  localparam logic [3:0] BUF_EN_RST = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // decoding of compare and buffer slots, shared by write and read paths
  function automatic logic [2:0] slot_of(input logic [7:0] addr, input logic [7:0] base);
    logic [7:0] d;
    d = addr - base;
    slot_of = {(addr >= base) && (d < SLOT_SPAN) && (d[1:0] == 2'h0), d[3:2]};
  endfunction
endpackage
`default_nettype wire

// file: logic/tcp_reg_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tcp_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  modport bus (output wr_en, output addr, output wr_data, input rd_data);
  modport regs (input wr_en, input addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// file: logic/tcp_timer.sv
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1 - counter advances once per clock; period lasts period compare plus one
// RULE2 - counter equal to period compare clears counter and sets period flag
// RULE3 - after period match counter keeps counting when continue is selected
// RULE4 - pin a goes active at its set compare, inactive at period match
// RULE5 - pin b goes active at its set compare, inactive at its reset compare
// RULE6 - active level selectable per pin; pins start at the inactive level
// RULE7 - four buffer registers shadow period, pin a set, pin b reset, pin b set
// RULE8 - enabled buffers load into their compare registers at period match
// RULE9 - each pin has its own output enable; disabled pins are released
// RULE10 - period match raises the interrupt only when enabled
// RULE11 - software clears the period flag from the interrupt handler
// RULE12 - clock gate at zero holds timer in reset and ignores register writes
// RULE13 - clock gate at one runs timer and allows reads and writes
// RULE14 - writing zero to the run bit stops the counter
// RULE15 - writing one to the run bit starts the counter
// RULE16 - continue select zero stops at period match, one keeps counting
module tcp_timer import tcp_pkg::*; #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // pwm pins
  output logic output_pin_a,
  output logic output_pin_a_oe,
  output logic output_pin_b,
  output logic output_pin_b_oe,
  // interrupt
  output logic period_match_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic gate;
    logic run;
    logic cont;
    logic [3:0] buf_en;
    logic [1:0] out_dis;
    logic [1:0] act_hi;
    logic flag;
    logic ien;
    logic [CNT_W-1:0] cnt;
    logic [3:0][CNT_W-1:0] cmp;
    logic [3:0][CNT_W-1:0] bufr;
  } tcp_state_t;

  localparam tcp_state_t ST_RST = '{gate: 1'b0, run: 1'b0, cont: 1'b0, buf_en: BUF_EN_RST,
    out_dis: OUT_DIS_RST, act_hi: LEVEL_RST, flag: 1'b0, ien: 1'b0, cnt: '0, cmp: '1, bufr: '1};

  tcp_state_t s_reg, s_next;
  tcp_reg_if rif ();
  logic per_match;
  logic [1:0] set_evt;
  logic [1:0] clr_evt;
  logic [1:0] pin_lvl;
  logic [2:0] wr_cmp;
  logic [2:0] wr_buf;
  logic [2:0] rd_cmp;
  logic [2:0] rd_buf;
  logic gw;

  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  tcp_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .rif(rif.bus)
  );

  // ----------------------------------------------------------------
  // compare events
  // ----------------------------------------------------------------
  assign per_match = s_reg.run && (s_reg.cnt == s_reg.cmp[SLOT_PERIOD]); // RULE2
  assign set_evt[0] = s_reg.run && (s_reg.cnt == s_reg.cmp[SLOT_A_SET]); // RULE4
  assign clr_evt[0] = per_match; // RULE4
  assign set_evt[1] = s_reg.run && (s_reg.cnt == s_reg.cmp[SLOT_B_SET]); // RULE5
  assign clr_evt[1] = s_reg.run && (s_reg.cnt == s_reg.cmp[SLOT_B_RST]); // RULE5
  assign wr_cmp = slot_of(rif.addr, OFS_CMP_BASE);
  assign wr_buf = slot_of(rif.addr, OFS_BUF_BASE);
  assign rd_cmp = wr_cmp;
  assign rd_buf = wr_buf;
  // writes reach the timer only while its clock is supplied; the gate itself is always writable
  assign gw = rif.wr_en && s_reg.gate; // RULE12 RULE13

  always_comb begin
    s_next = s_reg;
    // counter, stop or continue at period match
    if (s_reg.run) begin
      if (per_match) begin
        s_next.cnt = '0; // RULE2
        s_next.run = s_reg.cont; // RULE3 RULE16
      end else begin
        s_next.cnt = s_reg.cnt + CNT_W'(1); // RULE1
      end
    end
    // software clear of the flag first, so a match in the same cycle wins
    if (gw && rif.addr == OFS_CLEAR && rif.wr_data[FLAG_BIT]) begin
      s_next.flag = 1'b0;
    end
    if (gw) begin
      case (rif.addr)
        OFS_START: begin
          s_next.run = rif.wr_data[RUN_BIT]; // RULE14 RULE15
          s_next.cont = rif.wr_data[CONT_BIT]; // RULE16
        end
        OFS_MODE: s_next.buf_en = rif.wr_data[BUF_LSB +: 4]; // RULE7
        OFS_OUT_DIS: s_next.out_dis = rif.wr_data[1:0]; // RULE9
        OFS_LEVEL: s_next.act_hi = rif.wr_data[1:0]; // RULE6
        OFS_IEN: s_next.ien = rif.wr_data[FLAG_BIT]; // RULE10
        OFS_COUNT: s_next.cnt = rif.wr_data[CNT_W-1:0];
        default: begin
          if (wr_cmp[2]) begin
            s_next.cmp[wr_cmp[1:0]] = rif.wr_data[CNT_W-1:0];
          end
          if (wr_buf[2]) begin
            s_next.bufr[wr_buf[1:0]] = rif.wr_data[CNT_W-1:0];
          end
        end
      endcase
    end
    if (per_match) begin
      s_next.flag = 1'b1; // RULE2
      // buffered period and duty values only take effect on a period boundary
      for (int i = 0; i < 4; i++) begin
        if (s_reg.buf_en[i]) begin
          s_next.cmp[i] = s_reg.bufr[i]; // RULE7 RULE8
        end
      end
    end
    if (rif.wr_en && rif.addr == OFS_CLK_EN) begin
      s_next.gate = rif.wr_data[CLK_GATE_BIT]; // RULE13
    end
    // a stopped clock gate keeps everything but the gate itself at reset
    if (!s_reg.gate) begin
      s_next = ST_RST; // RULE12
      s_next.gate = (rif.wr_en && rif.addr == OFS_CLK_EN) ? rif.wr_data[CLK_GATE_BIT] : 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= ST_RST;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rif.rd_data = 32'h0000_0000;
    case (rif.addr)
      OFS_CLK_EN: rif.rd_data[CLK_GATE_BIT] = s_reg.gate;
      OFS_START: begin
        rif.rd_data[RUN_BIT] = s_reg.run;
        rif.rd_data[CONT_BIT] = s_reg.cont;
      end
      OFS_MODE: rif.rd_data[BUF_LSB +: 4] = s_reg.buf_en;
      OFS_OUT_DIS: rif.rd_data[1:0] = s_reg.out_dis;
      OFS_LEVEL: rif.rd_data[1:0] = s_reg.act_hi;
      OFS_STATUS: rif.rd_data[FLAG_BIT] = s_reg.flag;
      OFS_IEN: rif.rd_data[FLAG_BIT] = s_reg.ien;
      OFS_COUNT: rif.rd_data[CNT_W-1:0] = s_reg.cnt;
      default: begin
        if (rd_cmp[2]) begin
          rif.rd_data[CNT_W-1:0] = s_reg.cmp[rd_cmp[1:0]];
        end else if (rd_buf[2]) begin
          rif.rd_data[CNT_W-1:0] = s_reg.bufr[rd_buf[1:0]];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_pin
    tcp_pin_unit u_pin (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .hold(!s_reg.gate),
      .set_evt(set_evt[g]),
      .clr_evt(clr_evt[g]),
      .act_hi(s_reg.act_hi[g]), // RULE6
      .pin_o(pin_lvl[g])
    );
  end

  assign output_pin_a = pin_lvl[0];
  assign output_pin_b = pin_lvl[1];
  // a disabled pin is handed back to general port use
  assign output_pin_a_oe = !s_reg.out_dis[0]; // RULE9
  assign output_pin_b_oe = !s_reg.out_dis[1]; // RULE9
  assign period_match_irq = s_reg.flag && s_reg.ien; // RULE10 RULE11

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  cnt_adv_a: assert property (ce && s_reg.gate && s_reg.run && !per_match && !rif.wr_en // RULE1
    |=> s_reg.cnt == $past(s_reg.cnt) + CNT_W'(1))
    else $error("counter did not advance");
  ce_freeze_a: assert property (!ce // RULE1
    |=> s_reg == $past(s_reg))
    else $error("state moved while clock enable low");
  per_clear_a: assert property (ce && s_reg.gate && per_match && !rif.wr_en // RULE2
    |=> s_reg.cnt == '0 && s_reg.flag)
    else $error("period match did not clear and flag");
  flag_sticky_a: assert property (ce && s_reg.gate && s_reg.flag && !(gw && rif.addr == OFS_CLEAR) // RULE2
    |=> s_reg.flag)
    else $error("period flag dropped without clear");
  cont_run_a: assert property (ce && s_reg.gate && per_match && s_reg.cont && !rif.wr_en // RULE3
    |=> s_reg.run ##1 s_reg.cnt == CNT_W'(1))
    else $error("counter halted in continue mode");
  stop_match_a: assert property (ce && s_reg.gate && per_match && !s_reg.cont && !rif.wr_en // RULE16
    |=> !s_reg.run)
    else $error("counter kept running in stop mode");
  pin_a_set_a: assert property (ce && s_reg.gate && set_evt[0] && !per_match && s_reg.act_hi[0] // RULE4
    |=> output_pin_a)
    else $error("pin a not active after set match");
  pin_a_clr_a: assert property (ce && s_reg.gate && per_match && s_reg.act_hi[0] // RULE4
    |=> !output_pin_a)
    else $error("pin a not inactive after period match");
  pin_b_set_a: assert property (ce && s_reg.gate && set_evt[1] && !clr_evt[1] && s_reg.act_hi[1] // RULE5
    |=> output_pin_b)
    else $error("pin b not active after set match");
  pin_b_clr_a: assert property (ce && s_reg.gate && clr_evt[1] && s_reg.act_hi[1] // RULE5
    |=> !output_pin_b)
    else $error("pin b not inactive after reset match");
  low_active_a: assert property (ce && s_reg.gate && set_evt[0] && !per_match && !s_reg.act_hi[0] // RULE6
    |=> !output_pin_a)
    else $error("active low pin a not driven low");
  init_low_a: assert property (!s_reg.gate ##1 !s_reg.gate ##1 !s_reg.gate // RULE6
    |-> !output_pin_a && !output_pin_b && !output_pin_a_oe && !output_pin_b_oe)
    else $error("pins not inactive in reset");
  buf_xfer_a: assert property (ce && s_reg.gate && per_match && s_reg.buf_en[0] && !rif.wr_en // RULE8
    |=> s_reg.cmp[0] == $past(s_reg.bufr[0]))
    else $error("period buffer not loaded");
  buf_pin_b_a: assert property (ce && s_reg.gate && per_match && s_reg.buf_en[3] && !rif.wr_en // RULE7
    |=> s_reg.cmp[3] == $past(s_reg.bufr[3]))
    else $error("pin b set buffer not loaded");
  oe_write_a: assert property (ce && gw && rif.addr == OFS_OUT_DIS // RULE9
    |=> output_pin_a_oe == !$past(rif.wr_data[0]) && output_pin_b_oe == !$past(rif.wr_data[1]))
    else $error("output enable write lost");
  irq_gate_a: assert property (period_match_irq // RULE10
    |-> s_reg.ien && s_reg.flag && s_reg.gate)
    else $error("interrupt without enabled flag");
  irq_rise_a: assert property (ce && s_reg.gate && per_match && s_reg.ien && !rif.wr_en // RULE10
    |=> period_match_irq)
    else $error("enabled period match raised no interrupt");
  flag_clear_a: assert property (ce && gw && rif.addr == OFS_CLEAR && rif.wr_data[FLAG_BIT] && !per_match // RULE11
    |=> !s_reg.flag)
    else $error("period flag not cleared");
  gate_hold_a: assert property (ce && !s_reg.gate // RULE12
    |=> s_reg.cnt == '0 && !s_reg.run && !s_reg.flag)
    else $error("timer not held while gated");
  gate_write_a: assert property (ce && rif.wr_en && rif.addr == OFS_CLK_EN // RULE13
    |=> s_reg.gate == $past(rif.wr_data[CLK_GATE_BIT]))
    else $error("clock gate write lost");
  run_write_a: assert property (ce && gw && rif.addr == OFS_START // RULE14 RULE15
    |=> s_reg.run == $past(rif.wr_data[RUN_BIT]))
    else $error("run bit write lost");
  count_hold_a: assert property (ce && s_reg.gate && !s_reg.run && !rif.wr_en // RULE14
    |=> s_reg.cnt == $past(s_reg.cnt))
    else $error("stopped counter moved");

  per_match_c: cover property (ce && per_match && s_reg.cont);
  irq_c: cover property (period_match_irq);
  pin_b_pulse_c: cover property ($rose(output_pin_b) ##[1:100] $fell(output_pin_b));
  buf_c: cover property (per_match && (s_reg.buf_en == 4'hF));
  ce_freeze_c: cover property (!ce ##1 ce);
endmodule // tcp_timer
`default_nettype wire

// file: test/tcp_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tcp_timer_tb import tcp_pkg::*; ;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} tcp_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic hreadyout, hresp, output_pin_a, output_pin_a_oe, output_pin_b, output_pin_b_oe, period_match_irq;
  logic [31:0] hrdata;
  logic [31:0] q;
  int err_count = 0;
  int compares = 0;
  // reads carry the expected word in d; writes carry the data
  tcp_row_t rows [0:16] = '{
    '{1'b0, 8'h00, 32'h0000_0000},
    '{1'b1, 8'h24, 32'h0000_0005},
    '{1'b0, 8'h24, 32'h0000_FFFF},
    '{1'b1, 8'h00, 32'h0000_0010},
    '{1'b0, 8'h00, 32'h0000_0010},
    '{1'b1, 8'h24, 32'h0000_0009},
    '{1'b0, 8'h24, 32'h0000_0009},
    '{1'b0, 8'h0C, 32'h0000_0003},
    '{1'b0, 8'h10, 32'h0000_0003},
    '{1'b0, 8'h08, 32'h0000_0000},
    '{1'b0, 8'h2C, 32'h0000_FFFF},
    '{1'b0, 8'h40, 32'h0000_FFFF},
    '{1'b1, 8'h44, 32'h0000_1234},
    '{1'b0, 8'h44, 32'h0000_0000},
    '{1'b1, 8'h14, 32'h0000_0001},
    '{1'b0, 8'h14, 32'h0000_0000},
    '{1'b0, 8'h18, 32'h0000_0000}
  };

  tcp_timer dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .output_pin_a(output_pin_a), .output_pin_a_oe(output_pin_a_oe),
    .output_pin_b(output_pin_b), .output_pin_b_oe(output_pin_b_oe), .period_match_irq(period_match_irq)
  );

  always #5 hclk = ~hclk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge hclk);
    while (hreadyout !== 1'b1) @(negedge hclk);
    q = hrdata;
    @(posedge hclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    chk(q, exp);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask

  // pins as {a, a_oe, b, b_oe, irq}
  task automatic pn(input logic [4:0] e);
    @(negedge hclk);
    chk({27'h000_0000, output_pin_a, output_pin_a_oe, output_pin_b, output_pin_b_oe, period_match_irq},
        {27'h000_0000, e});
    @(posedge hclk);
  endtask

  function automatic logic pv(input bit b);
    return b ? output_pin_b : output_pin_a;
  endfunction

  // one full high span then one full low span, counted in clock cycles
  task automatic meas(input bit b, input int hi_e, input int lo_e);
    int hi, lo;
    hi = 0;
    lo = 0;
    @(negedge hclk);
    while (pv(b) !== 1'b0) @(negedge hclk);
    while (pv(b) !== 1'b1) @(negedge hclk);
    while (pv(b) === 1'b1) begin
      hi++;
      @(negedge hclk);
    end
    while (pv(b) === 1'b0) begin
      lo++;
      @(negedge hclk);
    end
    chk(32'(hi), 32'(hi_e));
    chk(32'(lo), 32'(lo_e));
    @(posedge hclk);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end else begin
        rd(rows[i].a, rows[i].d);
      end
    end
    // period 10, pin a set 6, pin b set 2 and reset 5
    wr(8'h28, 32'h0000_0006);
    wr(8'h2C, 32'h0000_0005);
    wr(8'h30, 32'h0000_0002);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h1C, 32'h0000_0001);
    pn(5'b01010);
    wr(8'h04, 32'h0000_0005);
    meas(1'b0, 3, 7);
    meas(1'b1, 3, 7);
    // new values through all four buffers, period 20
    wr(8'h34, 32'h0000_0013);
    wr(8'h38, 32'h0000_000E);
    wr(8'h3C, 32'h0000_0008);
    wr(8'h40, 32'h0000_0004);
    // enable last, so no period match can load a buffer still at its reset value
    wr(8'h08, 32'h0000_00F0);
    repeat (40) @(posedge hclk);
    meas(1'b0, 5, 15);
    meas(1'b1, 4, 16);
    rd(8'h24, 32'h0000_0013);
    wr(8'h10, 32'h0000_0000);
    // pins take the new polarity one edge later; measure only after that
    @(posedge hclk);
    meas(1'b0, 15, 5);
    wr(8'h10, 32'h0000_0003);
    // single shot: stop at the next period match
    wr(8'h04, 32'h0000_0001);
    repeat (50) @(posedge hclk);
    rd(8'h04, 32'h0000_0000);
    rd(8'h20, 32'h0000_0000);
    rd(8'h14, 32'h0000_0001);
    pn(5'b01011);
    wr(8'h1C, 32'h0000_0000);
    pn(5'b01010);
    wr(8'h1C, 32'h0000_0001);
    pn(5'b01011);
    wr(8'h18, 32'h0000_0001);
    rd(8'h14, 32'h0000_0000);
    pn(5'b01010);
    // a stopped counter keeps a written value
    wr(8'h20, 32'h0000_0003);
    repeat (5) @(posedge hclk);
    rd(8'h20, 32'h0000_0003);
    wr(8'h0C, 32'h0000_0003);
    pn(5'b00000);
    wr(8'h00, 32'h0000_0000);
    rd(8'h24, 32'h0000_FFFF);
    rd(8'h04, 32'h0000_0000);
    // reset in mid-run
    wr(8'h00, 32'h0000_0010);
    wr(8'h0C, 32'h0000_0000);
    wr(8'h04, 32'h0000_0005);
    repeat (30) @(posedge hclk);
    // four frozen cycles: the count read back is 31, not 35
    ce <= 1'b0;
    repeat (4) @(posedge hclk);
    ce <= 1'b1;
    rd(8'h20, 32'h0000_001F);
    hresetn <= 1'b0;
    pn(5'b00000);
    @(posedge hclk);
    hresetn <= 1'b1;
    rd(8'h00, 32'h0000_0000);
    conclude();
  end
endmodule // tcp_timer_tb
`default_nettype wire
